// >>> inc/rle_defs.svh
// register addresses, field positions, reset values and engine constants of the estimator
`ifndef RLE_DEFS_SVH
`define RLE_DEFS_SVH

// ----------------------------------------------------------------------------
// register map in external data space
// ----------------------------------------------------------------------------
`define RLE_ADDR_COORD      16'hdf55
`define RLE_ADDR_PARAM      16'hdf56
`define RLE_ADDR_CTRL       16'hdf57
`define RLE_ADDR_EST_X      16'hdf58
`define RLE_ADDR_EST_Y      16'hdf59

// ----------------------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------------------
`define RLE_CTRL_LAUNCH     0
`define RLE_CTRL_COORD_LD   1
`define RLE_CTRL_PARAM_LD   2
`define RLE_CTRL_DONE       3
`define RLE_CTRL_EN         4
`define RLE_RESET_BYTE      8'h00
`define RLE_READ_ZERO       8'h00

// ----------------------------------------------------------------------------
// load sequence lengths and parameter slots
// ----------------------------------------------------------------------------
`define RLE_COORD_WRITES    6'h20
`define RLE_PARAM_WRITES    5'h16
`define RLE_SLOT_A          5'h00
`define RLE_SLOT_N          5'h01
`define RLE_SLOT_XMIN       5'h02
`define RLE_SLOT_XSPAN      5'h03
`define RLE_SLOT_YMIN       5'h04
`define RLE_SLOT_YSPAN      5'h05
`define RLE_SLOT_RSSI0      5'h06
`define RLE_N_IDX_MASK      8'h1f

// ----------------------------------------------------------------------------
// exponent table in eighths: 1.000 .. 1.750, 1.875 .. 4.625, then 5.0 .. 8.0
// ----------------------------------------------------------------------------
`define RLE_N_FINE_FIRST    5'h04
`define RLE_N_TAIL_FIRST    5'h1b
`define RLE_N_COARSE_BASE   7'h08
`define RLE_N_FINE_BASE     7'h0b
`define RLE_N_TAIL0         7'h28
`define RLE_N_TAIL1         7'h2c
`define RLE_N_TAIL2         7'h30
`define RLE_N_TAIL3         7'h38
`define RLE_N_TAIL4         7'h40

// ----------------------------------------------------------------------------
// search engine
// ----------------------------------------------------------------------------
`define RLE_COORD_MAX       8'hff
`define RLE_LOSS_SCALE      8'h0c
`define RLE_COST_INIT       24'hffffff
`define RLE_REF_LAST        4'hf

`endif

// >>> inc/rle_pkg.sv
// types shared by the estimator top and its search engine
`default_nettype none

package rle_pkg;

  // one reference node: coordinates in 6.2 meters, signal magnitude in 0.5 dB steps
  typedef struct packed
  {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] rssi;
  } rle_ref_s;

  // radio and search-limit parameters
  typedef struct packed
  {
    logic [7:0] a_val;
    logic [4:0] n_idx;
    logic [7:0] x_min;
    logic [7:0] x_span;
    logic [7:0] y_min;
    logic [7:0] y_span;
  } rle_bounds_s;

  // search engine states
  typedef enum logic [2:0]
  {
    RLE_IDLE = 3'b001,
    RLE_SCAN = 3'b010,
    RLE_FIN  = 3'b100
  } rle_state_e;

endpackage : rle_pkg

`default_nettype wire

// >>> logic/rle_search.sv
// grid search engine: finds the candidate point that best fits the signal strengths
`timescale 1ns/1ps
`default_nettype none
`include "rle_defs.svh"

module rle_search
  import rle_pkg::*;
#(
  parameter int NUM_REFS = 16
)
(
  // clock, reset, clock enable
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  run_en,
  // command
  input  wire logic                  start,
  input  wire rle_bounds_s           bounds,
  input  wire rle_ref_s [15:0]       refs,
  // result
  output logic                       done,
  output logic [7:0]                 est_x,
  output logic [7:0]                 est_y
);

  if (NUM_REFS != 16)
    $error("rle_search serves exactly sixteen reference slots");

  rle_state_e  state_r;
  logic [7:0]  off_x_r;
  logic [7:0]  off_y_r;
  logic [3:0]  ref_r;
  logic [23:0] acc_r;
  logic [23:0] best_cost_r;
  logic [7:0]  best_x_r;
  logic [7:0]  best_y_r;
  logic [6:0]  n_eighths;
  logic [7:0]  cand_x;
  logic [7:0]  cand_y;
  logic [8:0]  man;
  logic [15:0] lhs;
  logic [15:0] rhs;
  logic [7:0]  excess;
  logic [16:0] term;
  logic [23:0] total;
  logic        last_x;
  logic        last_y;
  rle_ref_s    cur;

  // exponent index to exponent value in eighths
  function automatic logic [6:0] n_lut(input logic [4:0] idx);
    logic [6:0] v;
    v = `RLE_N_TAIL4;
    if (idx < `RLE_N_FINE_FIRST)
      v = 7'(`RLE_N_COARSE_BASE + {idx, 1'b0});
    else if (idx < `RLE_N_TAIL_FIRST)
      v = 7'(`RLE_N_FINE_BASE + idx);
    else
    begin
      case (idx)
        5'h1b:   v = `RLE_N_TAIL0;
        5'h1c:   v = `RLE_N_TAIL1;
        5'h1d:   v = `RLE_N_TAIL2;
        5'h1e:   v = `RLE_N_TAIL3;
        default: v = `RLE_N_TAIL4;
      endcase
    end
    return v;
  endfunction : n_lut

  // fit term of one reference against the current candidate point
  always_comb
  begin
    cur       = refs[ref_r];
    n_eighths = n_lut(bounds.n_idx);
    cand_x    = 8'(bounds.x_min + off_x_r);
    cand_y    = 8'(bounds.y_min + off_y_r);
    man       = 9'((cand_x > cur.x ? cand_x - cur.x : cur.x - cand_x))
              + 9'((cand_y > cur.y ? cand_y - cur.y : cur.y - cand_y));
    excess    = (cur.rssi > bounds.a_val) ? 8'(cur.rssi - bounds.a_val) : 8'h00;
    lhs       = 16'(man * n_eighths);
    rhs       = 16'(excess * `RLE_LOSS_SCALE);
    term      = (cur.rssi == 8'h00) ? 17'h00000
              : (lhs > rhs) ? 17'(lhs - rhs) : 17'(rhs - lhs);
    total     = acc_r + 24'(term);
    last_x    = (off_x_r == bounds.x_span) || (cand_x == `RLE_COORD_MAX);
    last_y    = (off_y_r == bounds.y_span) || (cand_y == `RLE_COORD_MAX);
  end

  // sequencing: sixteen cycles per candidate, x inner, y outer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= RLE_IDLE;
      off_x_r <= 8'h00;
      off_y_r <= 8'h00;
      ref_r   <= 4'h0;
      acc_r   <= 24'h000000;
    end
    else if (run_en) // stalls while the engine is disabled
    begin
      if (start)
      begin
        state_r <= RLE_SCAN;
        off_x_r <= 8'h00;
        off_y_r <= 8'h00;
        ref_r   <= 4'h0;
        acc_r   <= 24'h000000;
      end
      else
      begin
        case (state_r)
          RLE_IDLE: state_r <= RLE_IDLE;
          RLE_SCAN:
          begin
            ref_r <= 4'(ref_r + 4'h1);
            acc_r <= (ref_r == `RLE_REF_LAST) ? 24'h000000 : total;
            if (ref_r == `RLE_REF_LAST)
            begin
              if (!last_x)
                off_x_r <= 8'(off_x_r + 8'h01);
              else
              begin
                off_x_r <= 8'h00;
                off_y_r <= 8'(off_y_r + 8'h01);
                if (last_y)
                  state_r <= RLE_FIN;
              end
            end
          end
          RLE_FIN:  state_r <= RLE_IDLE;
          default:  state_r <= RLE_IDLE;
        endcase
      end
    end
  end

  // best candidate so far; ties keep the earliest point
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      best_cost_r <= `RLE_COST_INIT;
      best_x_r    <= 8'h00;
      best_y_r    <= 8'h00;
    end
    else if (run_en && start)
      best_cost_r <= `RLE_COST_INIT;
    else if (run_en && state_r == RLE_SCAN && ref_r == `RLE_REF_LAST && total < best_cost_r)
    begin
      best_cost_r <= total;
      best_x_r    <= cand_x;
      best_y_r    <= cand_y;
    end
  end

  // results: x carries a one-step offset that wraps inside the window
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done  <= 1'b0;
      est_x <= 8'h00;
      est_y <= 8'h00;
    end
    else
    begin
      done <= run_en && !start && state_r == RLE_FIN;
      if (run_en && !start && state_r == RLE_FIN)
      begin
        est_x <= (best_x_r == bounds.x_min) ? 8'(bounds.x_min + bounds.x_span)
                                            : 8'(best_x_r - 8'h01);
        est_y <= best_y_r;
      end
    end
  end

endmodule : rle_search

`default_nettype wire

// >>> logic/rle_top.sv
// location estimator coprocessor: register port, load memories and result registers
//
// Function
// - exponent given as integer index 0..31
// - index maps to exponent through fixed table
// - zero signal strength marks unused reference slot
// - parameter order A, n, limits, sixteen strengths
// - estimates 0..63.75 m in 0.25 m steps
// - writing launch bit starts computation
// - no interrupt; completion seen by polling
// - estimates hold until next result or reset
// - registers at 0xdf55 through 0xdf59
// - sixteen coordinate pairs x0,y0..x15,y15, 6.2 format
// - A is unsigned with half-unit lsb
// - enable low gates off engine clock
// - launch clears completion flag unless a search finishes that cycle; reads as zero
`timescale 1ns/1ps
`default_nettype none
`include "rle_defs.svh"

module rle_top
  import rle_pkg::*;
#(
  parameter int NUM_REFS = 16
)
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // register port in external data space
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata
);

  if (NUM_REFS != 16)
    $error("rle_top serves exactly sixteen reference slots");

  // memory depths follow from the slot count: an x and a y byte per slot, and
  // the six radio and window bytes ahead of one strength byte per slot
  localparam int COORD_DEPTH = 2 * NUM_REFS;
  localparam int PARAM_DEPTH = NUM_REFS + int'(`RLE_SLOT_RSSI0);

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  // release through two flops so the rest of the block leaves reset cleanly;
  // assertion stays asynchronous so the block is quiet even without a clock
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  logic        wr_coord;
  logic        wr_param;
  logic        wr_ctrl;
  logic        launch;
  logic        en_r;
  logic        done_r;
  logic        coord_ld_r;
  logic        param_ld_r;
  logic [5:0]  coord_ptr_r;
  logic [4:0]  param_ptr_r;
  logic [7:0]  coord_last_r;
  logic [7:0]  param_last_r;
  logic [7:0]  est_x_r;
  logic [7:0]  est_y_r;
  logic [7:0]  ctrl_view;
  logic [7:0]  coord_mem_r [COORD_DEPTH];
  logic [7:0]  param_mem_r [PARAM_DEPTH];
  logic        eng_done;
  logic [7:0]  eng_x;
  logic [7:0]  eng_y;
  rle_bounds_s bounds;
  rle_ref_s [15:0] refs;

  // strobes are one cycle wide; a strobe held high would load one byte per
  // cycle, so the byte count is entirely in software's hands
  // byte-wide port at fixed addresses
  assign wr_coord = reg_wr && (reg_addr == `RLE_ADDR_COORD);
  assign wr_param = reg_wr && (reg_addr == `RLE_ADDR_PARAM);
  assign wr_ctrl  = reg_wr && (reg_addr == `RLE_ADDR_CTRL);
  assign launch   = wr_ctrl && reg_wdata[`RLE_CTRL_LAUNCH];

  // --------------------------------------------------------------------------
  // control bits
  // --------------------------------------------------------------------------
  // enable and load flags are plain read/write bits; every control write
  // rewrites all three, so a launch must resend the enable it wants kept
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      en_r       <= 1'b0;
      coord_ld_r <= 1'b0;
      param_ld_r <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      en_r       <= reg_wdata[`RLE_CTRL_EN];
      coord_ld_r <= reg_wdata[`RLE_CTRL_COORD_LD];
      param_ld_r <= reg_wdata[`RLE_CTRL_PARAM_LD];
    end
  end

  // completion flag: launch clears it, a finishing search sets it, set wins;
  // a launch on the very cycle of a finish therefore still reads as done
  // until the restarted search delivers, which polling software must allow for
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
      done_r <= 1'b0;
    else if (eng_done)
      done_r <= 1'b1;
    else if (launch)
      done_r <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // load pointers
  // --------------------------------------------------------------------------
  // a write of 1 to a load flag rewinds its pointer; pointers stop at the end
  // so extra writes cannot wrap onto slot zero; a short load leaves the tail
  // slots holding whatever the previous load put there
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      coord_ptr_r <= 6'h00;
      param_ptr_r <= 5'h00;
    end
    else
    begin
      if (wr_ctrl && reg_wdata[`RLE_CTRL_COORD_LD])
        coord_ptr_r <= 6'h00;
      else if (wr_coord && coord_ld_r && coord_ptr_r != `RLE_COORD_WRITES)
        coord_ptr_r <= 6'(coord_ptr_r + 6'h01);
      if (wr_ctrl && reg_wdata[`RLE_CTRL_PARAM_LD])
        param_ptr_r <= 5'h00;
      else if (wr_param && param_ld_r && param_ptr_r != `RLE_PARAM_WRITES)
        param_ptr_r <= 5'(param_ptr_r + 5'h01);
    end
  end

  // --------------------------------------------------------------------------
  // load memories
  // --------------------------------------------------------------------------
  // coordinate slot i holds x at 2i and y at 2i+1; the read-back byte follows
  // every write, loading or not, so software can verify the last byte sent
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      coord_last_r <= `RLE_RESET_BYTE;
      for (int i = 0; i < COORD_DEPTH; i++)
        coord_mem_r[i] <= `RLE_RESET_BYTE;
    end
    else if (wr_coord)
    begin
      coord_last_r <= reg_wdata;
      if (coord_ld_r && coord_ptr_r != `RLE_COORD_WRITES)
        coord_mem_r[coord_ptr_r[4:0]] <= reg_wdata;
    end
  end

  // parameter slots in the order A, n, limits, strengths
  // the engine reads these slots live, so reloading during a search upsets it
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      param_last_r <= `RLE_RESET_BYTE;
      for (int i = 0; i < PARAM_DEPTH; i++)
        param_mem_r[i] <= `RLE_RESET_BYTE;
    end
    else if (wr_param)
    begin
      param_last_r <= reg_wdata;
      if (param_ld_r && param_ptr_r != `RLE_PARAM_WRITES)
        param_mem_r[param_ptr_r] <= reg_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // engine inputs
  // --------------------------------------------------------------------------
  // index keeps only its five integer bits; A stays in half units
  // a search reads the window straight from these slots, with no snapshot
  assign bounds.a_val  = param_mem_r[`RLE_SLOT_A];
  assign bounds.n_idx  = 5'(param_mem_r[`RLE_SLOT_N] & `RLE_N_IDX_MASK);
  assign bounds.x_min  = param_mem_r[`RLE_SLOT_XMIN];
  assign bounds.x_span = param_mem_r[`RLE_SLOT_XSPAN];
  assign bounds.y_min  = param_mem_r[`RLE_SLOT_YMIN];
  assign bounds.y_span = param_mem_r[`RLE_SLOT_YSPAN];

  // one generate loop gathers each reference slot
  // a zero strength byte is how an unused slot is marked for the engine
  for (genvar g = 0; g < 16; g++)
  begin : g_ref
    assign refs[g].x    = coord_mem_r[2 * g];
    assign refs[g].y    = coord_mem_r[2 * g + 1];
    assign refs[g].rssi = param_mem_r[g + `RLE_SLOT_RSSI0];
  end

  // --------------------------------------------------------------------------
  // search engine
  // --------------------------------------------------------------------------
  // the enable acts as the engine's clock enable: a cleared enable freezes it
  // in place rather than aborting, which keeps the power saving cheap
  // a launch while disabled is dropped by the engine, only the flag clears
  rle_search #(
    .NUM_REFS (NUM_REFS)
  ) u_search (
    .clock  (clock),
    .rst_n  (rst_n_r),
    .run_en (en_r),
    .start  (launch),
    .bounds (bounds),
    .refs   (refs),
    .done   (eng_done),
    .est_x  (eng_x),
    .est_y  (eng_y)
  );

  // results load only when a search completes
  // writes to the estimate addresses decode to nothing, keeping them read only
  // est_x keeps the engine's one-step offset; software removes it
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      est_x_r <= `RLE_RESET_BYTE;
      est_y_r <= `RLE_RESET_BYTE;
    end
    else if (eng_done)
    begin
      est_x_r <= eng_x;
      est_y_r <= eng_y;
    end
  end

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  // status byte built from the field positions; reserved bits and launch read zero
  always_comb
  begin
    ctrl_view                     = `RLE_READ_ZERO;
    ctrl_view[`RLE_CTRL_EN]       = en_r;
    ctrl_view[`RLE_CTRL_DONE]     = done_r;
    ctrl_view[`RLE_CTRL_PARAM_LD] = param_ld_r;
    ctrl_view[`RLE_CTRL_COORD_LD] = coord_ld_r;
  end

  // unmapped addresses read zero so a stray poll never sees stale bits
  // registered read data, valid the cycle after the strobe; no interrupt
  // output exists, software polls the completion flag
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
      reg_rdata <= `RLE_READ_ZERO;
    else if (reg_rd)
    begin
      case (reg_addr)
        `RLE_ADDR_COORD: reg_rdata <= coord_last_r;
        `RLE_ADDR_PARAM: reg_rdata <= param_last_r;
        `RLE_ADDR_CTRL:  reg_rdata <= ctrl_view;
        `RLE_ADDR_EST_X: reg_rdata <= est_x_r;
        `RLE_ADDR_EST_Y: reg_rdata <= est_y_r;
        default:         reg_rdata <= `RLE_READ_ZERO;
      endcase
    end
  end

endmodule : rle_top

`default_nettype wire

// >>> tb/rle_top_chk.sv
// checker of the estimator register port, bound to the top module
`timescale 1ns/1ps
`default_nettype none
`include "rle_defs.svh"

module rle_top_chk
#(
  parameter int NUM_REFS = 16
)
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_rdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // address decode of the strobes the bench issues
  wire logic rd_ctrl  = reg_rd && reg_addr == `RLE_ADDR_CTRL;
  wire logic wr_ctrl  = reg_wr && reg_addr == `RLE_ADDR_CTRL;
  wire logic mapped   = reg_addr >= `RLE_ADDR_COORD && reg_addr <= `RLE_ADDR_EST_Y;
  // write data two cycles back, lines up with a read issued right after the write
  logic [7:0] wd1_r;
  logic [7:0] wd2_r;
  always_ff @(posedge clock)
  begin
    wd1_r <= reg_wdata;
    wd2_r <= wd1_r;
  end

  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_reset_zero: assert property (disable iff (1'b0) !reset_n |-> reg_rdata == 8'h00)
    else $error("read data not zero in reset");
  a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_fixed_bits: assert property (rd_ctrl |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[0])
    else $error("reserved or launch bit read as one");
  a_ctrl_readback: assert property (wr_ctrl ##1 rd_ctrl |=>
    {reg_rdata[4], reg_rdata[2:1]} == {wd2_r[4], wd2_r[2:1]})
    else $error("control bits not read back");
  a_launch_clears: assert property (wr_ctrl && reg_wdata[0] ##1 rd_ctrl |=> !reg_rdata[3])
    else $error("completion flag survived launch");
  a_coord_readback: assert property (reg_wr && reg_addr == `RLE_ADDR_COORD
    ##1 reg_rd && reg_addr == `RLE_ADDR_COORD |=> reg_rdata == wd2_r)
    else $error("coordinate port read back wrong");
  a_param_readback: assert property (reg_wr && reg_addr == `RLE_ADDR_PARAM
    ##1 reg_rd && reg_addr == `RLE_ADDR_PARAM |=> reg_rdata == wd2_r)
    else $error("parameter port read back wrong");

  // main scenarios
  c_launch: cover property (wr_ctrl && reg_wdata[0]);
  c_done_seen: cover property (rd_ctrl ##1 reg_rdata[3]);
  c_unmapped: cover property (reg_rd && !mapped);
endmodule : rle_top_chk

bind rle_top rle_top_chk #(.NUM_REFS(NUM_REFS)) u_rle_top_chk
(
  .clock     (clock),
  .reset_n   (reset_n),
  .reg_addr  (reg_addr),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_wdata (reg_wdata),
  .reg_rdata (reg_rdata)
);

`default_nettype wire

// >>> tb/rle_top_bench.sv
// self-checking bench of the location estimator
`timescale 1ns/1ps
`default_nettype none
`include "rle_defs.svh"

module rle_top_bench;
  logic        clock;
  logic        reset_n;
  logic [15:0] reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  got;
  logic [7:0]  xr;
  logic [7:0]  yr;
  int          miscompares;
  int          n_compared;

  rle_top u_rle_top (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // 200 mhz clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // bus tasks and comparison
  // ------------------------------------------------------------
  // strobe stays up between back-to-back writes, one write per cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_rd = 1'b0;
    reg_wr = 1'b1;
  endtask : wr

  task automatic idle();
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : idle

  // sampled a cycle late; read data holds until the next read
  task automatic rd(input logic [15:0] a);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    @(posedge clock);
    #1;
    got = reg_rdata;
  endtask : rd

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      miscompares++;
    end
  endtask : chk

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic do_reset();
    @(posedge clock);
    #1;
    reset_n = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge clock);
  endtask : do_reset

  // every mapped register and both neighbours read zero after reset
  task automatic check_zero();
    for (int i = 16'hdf54; i <= 16'hdf5a; i++)
    begin
      rd(16'(i));
      chk(got, 8'h00);
    end
  endtask : check_zero

  // bounded poll of the completion flag, no interrupt exists
  task automatic wait_done();
    int i;
    for (i = 0; i < 3000; i++)
    begin
      rd(`RLE_ADDR_CTRL);
      if (got[3] === 1'b1)
        break;
    end
    if (i == 3000)
    begin
      miscompares++;
      conclude();
    end
  endtask : wait_done

  // one live reference with zero path loss: the best point is the node itself
  task automatic run_case(input int k, input logic [7:0] px, input logic [7:0] py,
    input logic [7:0] a, input logic [4:0] n, input logic [7:0] xmin, input logic [7:0] xspan,
    input logic [7:0] ymin, input logic [7:0] yspan);
    int dx;
    wr(`RLE_ADDR_CTRL, 8'h12);
    repeat (3) wr(`RLE_ADDR_COORD, 8'($urandom));
    wr(`RLE_ADDR_CTRL, 8'h12);
    for (int i = 0; i < 16; i++)
    begin
      wr(`RLE_ADDR_COORD, i == k ? px : 8'($urandom));
      wr(`RLE_ADDR_COORD, i == k ? py : 8'($urandom));
    end
    repeat (2) wr(`RLE_ADDR_COORD, 8'($urandom));
    wr(`RLE_ADDR_CTRL, 8'h14);
    wr(`RLE_ADDR_PARAM, a);
    wr(`RLE_ADDR_PARAM, {3'h0, n});
    wr(`RLE_ADDR_PARAM, xmin);
    wr(`RLE_ADDR_PARAM, xspan);
    wr(`RLE_ADDR_PARAM, ymin);
    wr(`RLE_ADDR_PARAM, yspan);
    for (int i = 0; i < 16; i++)
      wr(`RLE_ADDR_PARAM, i == k ? a : 8'h00);
    // a wrapping pointer would zero the path-loss value and move the answer
    repeat (2) wr(`RLE_ADDR_PARAM, 8'h00);
    wr(`RLE_ADDR_CTRL, 8'h10);
    wr(`RLE_ADDR_CTRL, 8'h11);
    wait_done();
    rd(`RLE_ADDR_EST_X);
    xr = got;
    rd(`RLE_ADDR_EST_Y);
    yr = got;
    dx = (int'(xr) - int'(xmin) + 1) % (int'(xspan) + 1);
    chk(8'(dx + int'(xmin)), px);
    chk(yr, py);
  endtask : run_case

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] xmin, xspan, ymin, yspan, px, py, last;
    int k;
    reset_n = 1'b0;
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(32'h29c1e571));
    do_reset();
    check_zero();
    // every exponent index once, window corners and edge slots among them
    for (int t = 0; t < 32; t++)
    begin
      xspan = 8'($urandom_range(0, 7));
      yspan = 8'($urandom_range(0, 7));
      xmin = t == 5 ? 8'hff - xspan : 8'($urandom_range(0, 255 - xspan));
      ymin = t == 5 ? 8'hff - yspan : 8'($urandom_range(0, 255 - yspan));
      px = t == 0 ? xmin : t == 1 ? xmin + xspan : xmin + 8'($urandom_range(0, xspan));
      py = t == 1 ? ymin + yspan : ymin + 8'($urandom_range(0, yspan));
      k = t == 2 ? 15 : t == 3 ? 0 : $urandom_range(0, 15);
      run_case(k, px, py, 8'($urandom_range(80, 100)), 5'(t), xmin, xspan, ymin, yspan);
    end
    // relaunch clears the flag, then freeze the engine well past its latency
    wr(`RLE_ADDR_CTRL, 8'h11);
    rd(`RLE_ADDR_CTRL);
    chk(got, 8'h10);
    wr(`RLE_ADDR_CTRL, 8'h00);
    idle();
    repeat (1500) @(posedge clock);
    rd(`RLE_ADDR_CTRL);
    chk(got, 8'h00);
    wr(`RLE_ADDR_CTRL, 8'h10);
    wait_done();
    rd(`RLE_ADDR_EST_X);
    chk(got, xr);
    rd(`RLE_ADDR_EST_Y);
    chk(got, yr);
    // launch that also clears the enable: the search starts then freezes, so the flag stays clear
    wr(`RLE_ADDR_CTRL, 8'h01);
    idle();
    repeat (1500) @(posedge clock);
    rd(`RLE_ADDR_CTRL);
    chk(got, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      last = i == 0 ? 8'h02 : i == 1 ? 8'h04 : i == 2 ? 8'h16 : i == 3 ? 8'he6 : 8'h10;
      wr(`RLE_ADDR_CTRL, last);
      rd(`RLE_ADDR_CTRL);
      chk(got, last & 8'h16);
    end
    // new coordinates and writes to the estimate registers leave the estimates alone
    wr(`RLE_ADDR_CTRL, 8'h12);
    for (int i = 0; i < 32; i++)
    begin
      last = 8'($urandom);
      wr(`RLE_ADDR_COORD, last);
    end
    rd(`RLE_ADDR_COORD);
    chk(got, last);
    wr(`RLE_ADDR_CTRL, 8'h10);
    wr(`RLE_ADDR_EST_X, ~xr);
    wr(`RLE_ADDR_EST_Y, ~yr);
    // with its load flag clear a parameter write only moves the read-back byte
    wr(`RLE_ADDR_PARAM, ~last);
    rd(`RLE_ADDR_PARAM);
    chk(got, ~last);
    rd(`RLE_ADDR_EST_X);
    chk(got, xr);
    rd(`RLE_ADDR_EST_Y);
    chk(got, yr);
    // a reset in mid-run clears every register again
    do_reset();
    check_zero();
    conclude();
  end
endmodule : rle_top_bench

`default_nettype wire
